//--- pkg/ascd_pkg.sv
// Purpose: Shared constants and types for the audio serial config/clock divider
// Assumes: 32-bit AXI4-Lite register bus, 125 MHz aclk
// Notes:   Offsets are byte addresses
package ascd_pkg;
  // Register byte offsets
  localparam logic [7:0] CFG_OFS = 8'h1C;  // audio_port_config
  localparam logic [7:0] DIV_OFS = 8'h20;  // audio_clock_divider
  localparam logic [7:0] STA_OFS = 8'h24;  // Block status
  // Reset values
  localparam logic [15:0] CFG_RST = 16'h0000;
  localparam logic [15:0] DIV_RST = 16'h0002;
  // Config field positions
  localparam int CHLEN_B = 0;
  localparam int DLEN_LO = 1;
  localparam int IDLE_B  = 3;
  localparam int STD_LO  = 4;
  localparam int PSYNC_B = 7;
  localparam int ROLE_LO = 8;
  localparam int EN_B    = 10;
  localparam int PROT_B  = 11;
  // Divider field positions
  localparam int ODD_B   = 8;
  localparam int MCOE_B  = 9;
  // Writable masks
  localparam logic [15:0] CFG_MASK = 16'h0FBF;
  localparam logic [15:0] DIV_MASK = 16'h03FF;
  // AXI responses
  localparam logic [1:0] RESP_OK  = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;
  // Framing standards
  typedef enum logic [1:0] {
    ASCD_STD_STD   = 2'h0,
    ASCD_STD_LEFT  = 2'h1,
    ASCD_STD_RIGHT = 2'h2,
    ASCD_STD_PCM   = 2'h3
  } ascd_std_t;
  // Role and direction
  typedef enum logic [1:0] {
    ASCD_ROLE_STX = 2'h0,
    ASCD_ROLE_SRX = 2'h1,
    ASCD_ROLE_MTX = 2'h2,
    ASCD_ROLE_MRX = 2'h3
  } ascd_role_t;
  // Decoded configuration seen by the serial engine
  typedef struct packed {
    logic       active;      // Audio mode and enabled
    logic       master;
    logic       transmit;
    ascd_std_t  standard;
    logic       pcm_long;
    logic [5:0] sample_bits; // 16, 24 or 32; 0 when illegal
    logic       len_bad;
  } ascd_cfg_t;
endpackage

//--- core/ascd_core.sv
// Purpose: Audio serial configuration registers and master clock divider
// Assumes: AXI4-Lite slave, one outstanding read and write
// Notes:   Serial engine itself lives elsewhere; this block drives clock outputs
// Notes on behaviour
// - Idle clock level follows idle bit
// - Two-bit field selects framing standard
// - Sync length bit only matters in PCM
// - Role field: slave/master, transmit/receive
// - Interface runs only while enable set
// - Protocol bit writable only when disabled
// - Config fields writable only while disabled
// - Audio fields ignored in serial port mode
// - Divide by 2N, or 2N+1 when odd
// - Divider settings apply only as master
// - Master clock output follows its enable
// - Sample length 16/24/32, 11 not permitted
`timescale 1ns/1ps
module ascd_core #(
  parameter int ADDR_W = 8  // AXI address width
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  output logic                   bit_clock,
  output logic                   master_clock,
  output logic                   master_clock_oe_n,
  output ascd_pkg::ascd_cfg_t    cfg_out
);

  // Elaboration check: offsets need at least 6 address bits
  if (ADDR_W < 6 || ADDR_W > 8) begin : g_chk
    $error("ascd_core: ADDR_W must be 6..8");
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register state
  logic [15:0] cfg_r,  cfg_nxt;   // audio_port_config
  logic [15:0] div_r,  div_nxt;   // audio_clock_divider
  logic [ADDR_W-1:0] awa_r, awa_nxt; // Latched write address
  logic [31:0] wd_r,   wd_nxt;    // Latched write data
  logic [3:0]  ws_r,   ws_nxt;    // Latched strobes
  logic        awh_r,  awh_nxt;   // Address held
  logic        wh_r,   wh_nxt;    // Data held
  logic        bv_r,   bv_nxt;
  logic [1:0]  br_r,   br_nxt;
  logic        rv_r,   rv_nxt;
  logic [31:0] rd_r,   rd_nxt;
  logic [1:0]  rr_r,   rr_nxt;

  // Merge write data into a 16-bit register by byte strobes
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                          input logic [3:0] s, input logic [15:0] m);
    logic [15:0] v;
    v = old;
    if (s[0]) v[7:0]  = d[7:0];
    if (s[1]) v[15:8] = d[15:8];
    return (v & m) | (old & ~m);
  endfunction

  // Aligned byte offset of an address
  function automatic logic [7:0] ofs(input logic [ADDR_W-1:0] a);
    return 8'(a) & 8'hFC;
  endfunction

  logic audio_on;    // Audio mode and enabled
  assign audio_on = cfg_r[ascd_pkg::PROT_B] & cfg_r[ascd_pkg::EN_B];

  ////////////////////////////////////////////////////////////////////////////
  // Write channel: address and data accepted in either order
  always_comb begin
    logic        go;
    logic [15:0] nc;
    logic        en_only;
    go      = 1'b0;
    nc      = cfg_r;
    en_only = 1'b0;
    awa_nxt = awa_r;
    wd_nxt  = wd_r;
    ws_nxt  = ws_r;
    awh_nxt = awh_r;
    wh_nxt  = wh_r;
    bv_nxt  = bv_r;
    br_nxt  = br_r;
    cfg_nxt = cfg_r;
    div_nxt = div_r;
    // Capture address
    if (s_axi_awvalid && s_axi_awready) begin
      awa_nxt = s_axi_awaddr;
      awh_nxt = 1'b1;
    end
    // Capture data
    if (s_axi_wvalid && s_axi_wready) begin
      wd_nxt = s_axi_wdata;
      ws_nxt = s_axi_wstrb;
      wh_nxt = 1'b1;
    end
    // Retire response
    if (bv_r && s_axi_bready) begin
      bv_nxt = 1'b0;
    end
    // Perform write once both halves are held and no response pending
    go = awh_r && wh_r && !bv_r;
    if (go) begin
      awh_nxt = 1'b0;
      wh_nxt  = 1'b0;
      bv_nxt  = 1'b1;
      br_nxt  = ascd_pkg::RESP_OK;
      unique case (ofs(awa_r))
        ascd_pkg::CFG_OFS: begin
          nc = merge16(cfg_r, wd_r, ws_r, ascd_pkg::CFG_MASK);
          // While the port is enabled only the enable bit may change
          if (cfg_r[ascd_pkg::EN_B]) begin
            en_only = 1'b1;
          end
          if (en_only) begin
            cfg_nxt = cfg_r;
            cfg_nxt[ascd_pkg::EN_B] = nc[ascd_pkg::EN_B];
          end else begin
            cfg_nxt = nc;
            // Protocol fixed while the port is enabled; enable
            // and protocol change are taken from the same write
            cfg_nxt[ascd_pkg::PROT_B] = cfg_r[ascd_pkg::EN_B] ? cfg_r[ascd_pkg::PROT_B]
                                        : nc[ascd_pkg::PROT_B];
          end
        end
        ascd_pkg::DIV_OFS: begin
          // Ignored while enabled
          if (!cfg_r[ascd_pkg::EN_B]) begin
            div_nxt = merge16(div_r, wd_r, ws_r, ascd_pkg::DIV_MASK);
          end
        end
        ascd_pkg::STA_OFS: begin
          // Read-only: write ignored, answered OKAY
        end
        default: begin
          br_nxt = ascd_pkg::RESP_ERR;
        end
      endcase
    end
    if (!aresetn) begin
      cfg_nxt = ascd_pkg::CFG_RST;
      div_nxt = ascd_pkg::DIV_RST;
      awh_nxt = 1'b0;
      wh_nxt  = 1'b0;
      bv_nxt  = 1'b0;
      br_nxt  = ascd_pkg::RESP_OK;
    end
  end

  // Write registers
  always_ff @(posedge aclk) begin
    cfg_r <= cfg_nxt;
    div_r <= div_nxt;
    awa_r <= awa_nxt;
    wd_r  <= wd_nxt;
    ws_r  <= ws_nxt;
    awh_r <= awh_nxt;
    wh_r  <= wh_nxt;
    bv_r  <= bv_nxt;
    br_r  <= br_nxt;
  end

  assign s_axi_awready = !awh_r;
  assign s_axi_wready  = !wh_r;
  assign s_axi_bvalid  = bv_r;
  assign s_axi_bresp   = br_r;

  ////////////////////////////////////////////////////////////////////////////
  // Read channel: one cycle after address acceptance
  always_comb begin
    rv_nxt = rv_r;
    rd_nxt = rd_r;
    rr_nxt = rr_r;
    if (rv_r && s_axi_rready) begin
      rv_nxt = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      rv_nxt = 1'b1;
      rr_nxt = ascd_pkg::RESP_OK;
      rd_nxt = 32'h0000_0000;
      unique case (ofs(s_axi_araddr))
        ascd_pkg::CFG_OFS: rd_nxt = {16'h0000, cfg_r};
        ascd_pkg::DIV_OFS: rd_nxt = {16'h0000, div_r};
        // Live state: bit0 audio active, bit1 bit clock, bit2 length illegal
        ascd_pkg::STA_OFS: rd_nxt = {29'h0, cfg_out.len_bad, bit_clock, audio_on};
        default: rr_nxt = ascd_pkg::RESP_ERR;
      endcase
    end
    if (!aresetn) begin
      rv_nxt = 1'b0;
      rd_nxt = 32'h0000_0000;
      rr_nxt = ascd_pkg::RESP_OK;
    end
  end

  // Read registers
  always_ff @(posedge aclk) begin
    rv_r <= rv_nxt;
    rd_r <= rd_nxt;
    rr_r <= rr_nxt;
  end

  assign s_axi_arready = !rv_r;
  assign s_axi_rvalid  = rv_r;
  assign s_axi_rdata   = rd_r;
  assign s_axi_rresp   = rr_r;

  ////////////////////////////////////////////////////////////////////////////
  // Configuration decode
  ascd_pkg::ascd_cfg_t cfg_d_r, cfg_d_nxt;
  always_comb begin
    logic [1:0] dl;
    dl = cfg_r[ascd_pkg::DLEN_LO +: 2];
    cfg_d_nxt = '0;
    cfg_d_nxt.active   = audio_on;
    cfg_d_nxt.master   = audio_on & cfg_r[ascd_pkg::ROLE_LO + 1];
    cfg_d_nxt.transmit = audio_on & ~cfg_r[ascd_pkg::ROLE_LO];
    cfg_d_nxt.standard = audio_on ? ascd_pkg::ascd_std_t'(cfg_r[ascd_pkg::STD_LO +: 2])
                                  : ascd_pkg::ASCD_STD_STD;
    cfg_d_nxt.pcm_long = audio_on && cfg_d_nxt.standard == ascd_pkg::ASCD_STD_PCM
                         && cfg_r[ascd_pkg::PSYNC_B];
    // Sample length decode; 11 not permitted
    unique case (dl)
      2'h0:    cfg_d_nxt.sample_bits = 6'h10;
      2'h1:    cfg_d_nxt.sample_bits = 6'h18;
      2'h2:    cfg_d_nxt.sample_bits = 6'h20;
      default: cfg_d_nxt.len_bad     = audio_on;
    endcase
    if (!audio_on) cfg_d_nxt.sample_bits = 6'h00;
    if (!aresetn) cfg_d_nxt = '0;
  end

  always_ff @(posedge aclk) begin
    cfg_d_r <= cfg_d_nxt;
  end
  assign cfg_out = cfg_d_r;

  ////////////////////////////////////////////////////////////////////////////
  // Clock divider: master clock is aclk/(2N+odd), bit clock follows it
  // Factor 0 or 1 are forbidden; they are served as 2 to keep a live clock
  logic [8:0] cnt_r,  cnt_nxt;
  logic       phs_r,  phs_nxt;  // Divided clock phase
  logic       bclk_r, bclk_nxt;
  logic       mclk_r, mclk_nxt;
  logic       mcoe_r, mcoe_nxt;
  always_comb begin
    logic [8:0] f;
    logic [8:0] tot;
    logic       run;
    f   = (div_r[7:0] < 8'h02) ? 9'h002 : {1'b0, div_r[7:0]};
    tot = 9'((f << 1) + {8'h00, div_r[ascd_pkg::ODD_B]});
    run = audio_on & cfg_r[ascd_pkg::ROLE_LO + 1];
    cnt_nxt  = cnt_r;
    phs_nxt  = phs_r;
    if (!run) begin
      cnt_nxt = 9'h000;
      phs_nxt = 1'b0;
    end else if (cnt_r == tot - 9'h001) begin
      cnt_nxt = 9'h000;
      phs_nxt = 1'b0;
    end else begin
      cnt_nxt = cnt_r + 9'h001;
      if (cnt_r == f - 9'h001) phs_nxt = 1'b1;
    end
    mclk_nxt = run & phs_nxt;
    mcoe_nxt = run & div_r[ascd_pkg::MCOE_B];
    // Idle level when not running, else divided phase from idle level
    bclk_nxt = cfg_r[ascd_pkg::IDLE_B] ^ (run & phs_nxt);
    if (!aresetn) begin
      cnt_nxt  = 9'h000;
      phs_nxt  = 1'b0;
      mclk_nxt = 1'b0;
      mcoe_nxt = 1'b0;
      bclk_nxt = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    cnt_r  <= cnt_nxt;
    phs_r  <= phs_nxt;
    bclk_r <= bclk_nxt;
    mclk_r <= mclk_nxt;
    mcoe_r <= mcoe_nxt;
  end

  assign bit_clock         = bclk_r;
  assign master_clock      = mclk_r & mcoe_r;
  assign master_clock_oe_n = ~mcoe_r;

endmodule // ascd_core

//--- testbench/ascd_core_assertions.sv
// Purpose: Bus and clock-output checks for ascd_core
// Assumes: One clock domain, synchronous active-low reset
// Notes:   Bound to every ascd_core instance
`timescale 1ns/1ps
module ascd_core_checker (
  input wire logic                aclk,
  input wire logic                aresetn,
  input wire logic                s_axi_awvalid,
  input wire logic                s_axi_awready,
  input wire logic                s_axi_wvalid,
  input wire logic                s_axi_wready,
  input wire logic                s_axi_bvalid,
  input wire logic                s_axi_bready,
  input wire logic                s_axi_arvalid,
  input wire logic                s_axi_arready,
  input wire logic                s_axi_rvalid,
  input wire logic                s_axi_rready,
  input wire logic [31:0]         s_axi_rdata,
  input wire logic                bit_clock,
  input wire logic                master_clock,
  input wire ascd_pkg::ascd_cfg_t cfg_out
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  ////////////////////////////////////////////////////////////////////////////////
  // A taken address blocks a second one until the response
  property p_aw_lock; s_axi_awvalid && s_axi_awready |=> !s_axi_awready; endproperty
  a_aw_lock: assert property (p_aw_lock) else $error("awready stayed high");
  property p_wr_lat;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid;
  endproperty
  a_wr_lat: assert property (p_wr_lat) else $error("write response late");
  property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
  a_b_hold: assert property (p_b_hold) else $error("bvalid dropped early");
  property p_rd_lat; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_rd_lat: assert property (p_rd_lat) else $error("read data late");
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data not held");
  property p_ar_block; s_axi_rvalid |-> !s_axi_arready; endproperty
  a_ar_block: assert property (p_ar_block) else $error("arready with rvalid");
  // Write responses are excluded, since an idle-level write moves the line
  property p_bclk_idle;
    (!cfg_out.active && !s_axi_bvalid) [*4] |-> $stable(bit_clock);
  endproperty
  a_bclk_idle: assert property (p_bclk_idle) else $error("bit clock moved");
  property p_mclk_gate; !cfg_out.active [*2] |-> !master_clock; endproperty
  a_mclk_gate: assert property (p_mclk_gate) else $error("master clock ran");
  property p_len;
    cfg_out.active |-> cfg_out.len_bad == (cfg_out.sample_bits == 6'h00);
  endproperty
  a_len: assert property (p_len) else $error("length flag mismatch");
  c_stall: cover property (s_axi_bvalid && !s_axi_bready);
  c_mclk: cover property ($rose(master_clock));
  c_master: cover property (cfg_out.active && cfg_out.master);
endmodule // ascd_core_checker

bind ascd_core ascd_core_checker u_chk (.*);

//--- testbench/ascd_codec_model.sv
// Purpose: Far-side codec model that measures an incoming clock line
// Assumes: Line sampled on aclk
// Notes:   Reports spacing of the last two rising edges in aclk cycles
`timescale 1ns/1ps
module ascd_codec_model (
  input  wire logic aclk,     // Sampling clock
  input  wire logic line_in,  // Clock line from the block
  output int        period    // Cycles between the last two rising edges
);
  logic last_r = 1'b0;  // Previous line level
  int   cnt_r  = 0;     // Cycles since the last rising edge
  int   per_r  = 0;     // Last measured spacing, one process drives it
  assign period = per_r;
  // A receiver only cares about rising edges, so only those are timed
  always @(posedge aclk) begin
    last_r <= line_in;
    cnt_r <= (line_in && !last_r) ? 1 : cnt_r + 1;
    if (line_in && !last_r) per_r <= cnt_r;
  end
endmodule // ascd_codec_model

//--- testbench/test_audio_serial_config_clock_div.sv
// Purpose: Self-checking bench for ascd_core
// Assumes: AXI4-Lite master drives after rising edges, samples at falling
// Notes:   Register mirror plus codec models judge the clock outputs
`timescale 1ns/1ps
module test_audio_serial_config_clock_div;
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic bit_clock, master_clock, master_clock_oe_n;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  ascd_pkg::ascd_cfg_t cfg_out;
  int n_errors, total_checks, per_bc, per_mc;
  int lens [4] = '{16, 24, 32, 0};  // Sample widths per length code
  logic [15:0] cfg_m, div_m;        // Register mirror
  ascd_core u_dut (
    .aclk              (aclk),
    .aresetn           (aresetn),
    .s_axi_awaddr      (s_axi_awaddr),
    .s_axi_awvalid     (s_axi_awvalid),
    .s_axi_awready     (s_axi_awready),
    .s_axi_wdata       (s_axi_wdata),
    .s_axi_wstrb       (s_axi_wstrb),
    .s_axi_wvalid      (s_axi_wvalid),
    .s_axi_wready      (s_axi_wready),
    .s_axi_bresp       (s_axi_bresp),
    .s_axi_bvalid      (s_axi_bvalid),
    .s_axi_bready      (s_axi_bready),
    .s_axi_araddr      (s_axi_araddr),
    .s_axi_arvalid     (s_axi_arvalid),
    .s_axi_arready     (s_axi_arready),
    .s_axi_rdata       (s_axi_rdata),
    .s_axi_rresp       (s_axi_rresp),
    .s_axi_rvalid      (s_axi_rvalid),
    .s_axi_rready      (s_axi_rready),
    .bit_clock         (bit_clock),
    .master_clock      (master_clock),
    .master_clock_oe_n (master_clock_oe_n),
    .cfg_out           (cfg_out)
  );
  ascd_codec_model u_bc (.aclk(aclk), .line_in(bit_clock), .period(per_bc));
  ascd_codec_model u_mc (.aclk(aclk), .line_in(master_clock), .period(per_mc));
  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic stop_test();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask
  function automatic logic [1:0] rsp(input logic [7:0] a);
    return (a == ascd_pkg::CFG_OFS || a == ascd_pkg::DIV_OFS || a == ascd_pkg::STA_OFS)
      ? ascd_pkg::RESP_OK : ascd_pkg::RESP_ERR;
  endfunction
  // Write; bready rises after a random stall and falls once the response handshake is seen
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw, w, b;
    logic [1:0] r;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    b = 1'b0;
    // Waits for the answer however long it takes; the watchdog ends a hang
    while (!b) begin
      @(negedge aclk);
      aw = s_axi_awvalid && s_axi_awready;
      w = s_axi_wvalid && s_axi_wready;
      b = s_axi_bvalid && s_axi_bready;
      r = s_axi_bresp;
      @(posedge aclk);
      if (aw) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
      s_axi_bready <= b ? 1'b0 : (s_axi_bready | 1'($urandom_range(0, 1)));
    end
    chk("bresp", rsp(a), b ? r : 2'bxx);
    if (a == ascd_pkg::DIV_OFS && !cfg_m[10]) div_m = d[15:0] & ascd_pkg::DIV_MASK;
    if (a == ascd_pkg::CFG_OFS) cfg_m = cfg_m[10] ? {cfg_m[15:11], d[10], cfg_m[9:0]}
      : d[15:0] & ascd_pkg::CFG_MASK;
  endtask
  task automatic rd(input logic [7:0] a);
    logic ar, b;
    logic [1:0] r;
    logic [31:0] d;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    b = 1'b0;
    while (!b) begin
      @(negedge aclk);
      ar = s_axi_arvalid && s_axi_arready;
      b = s_axi_rvalid && s_axi_rready;
      r = s_axi_rresp;
      d = s_axi_rdata;
      @(posedge aclk);
      if (ar) s_axi_arvalid <= 1'b0;
      s_axi_rready <= b ? 1'b0 : (s_axi_rready | 1'($urandom_range(0, 1)));
    end
    chk("rresp", rsp(a), b ? r : 2'bxx);
    if (a == ascd_pkg::CFG_OFS) chk("config", {16'h0000, cfg_m}, d);
    if (a == ascd_pkg::DIV_OFS) chk("divider", {16'h0000, div_m}, d);
    // Status is predictable only while audio mode is inactive (port off or serial mode): line at idle level
    if (a == ascd_pkg::STA_OFS && !(cfg_m[11] && cfg_m[10]))
      chk("status", {30'h0, cfg_m[3], 1'b0}, d);
  endtask
  // Decoded configuration once it has settled
  task automatic chk_cfg();
    logic act;
    repeat (3) @(posedge aclk);
    @(negedge aclk);
    act = cfg_m[11] & cfg_m[10];
    chk("active", act, cfg_out.active);
    if (act) begin
      chk("master", cfg_m[9], cfg_out.master);
      chk("transmit", !cfg_m[8], cfg_out.transmit);
      chk("standard", cfg_m[5:4], cfg_out.standard);
      chk("pcm_long", cfg_m[5:4] == 2'h3 && cfg_m[7], cfg_out.pcm_long);
      chk("sample_bits", lens[cfg_m[2:1]], cfg_out.sample_bits);
      chk("len_bad", cfg_m[2:1] == 2'h3, cfg_out.len_bad);
    end else begin
      // Audio fields must not leak out while the port is off or in serial mode
      chk("cfg_off", 32'h0, 32'(cfg_out));
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [7:0] a;
    logic [31:0] d;
    int n, odd, mc, idle, role, on;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    s_axi_wstrb = 4'hF;
    aresetn = 1'b0;
    cfg_m = ascd_pkg::CFG_RST;
    div_m = ascd_pkg::DIV_RST;
    void'($urandom(32'h122955CD));
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    rd(ascd_pkg::CFG_OFS);
    rd(ascd_pkg::DIV_OFS);
    rd(8'h08);
    wr(8'h08, 32'h0000FFFF);
    rd(ascd_pkg::STA_OFS);
    // Random traffic, locking writes included whenever enable lands set
    for (int i = 0; i < 12; i++) begin
      a = $urandom_range(0, 1) ? ascd_pkg::CFG_OFS : ascd_pkg::DIV_OFS;
      d = $urandom;
      d[7:0] = 8'($urandom_range(2, 255));
      wr(a, d);
      rd(a);
      chk_cfg();
    end
    // Divider at boundary and random factors, then a slave role
    for (int i = 0; i < 7; i++) begin
      n = (i == 0) ? 2 : (i == 1) ? 255 : $urandom_range(2, 60);
      odd = i % 2;
      mc = (i / 2) % 2;
      idle = i / 4;
      role = (i == 6) ? 0 : 2 + $urandom_range(0, 1);
      on = role >= 2 && mc;
      wr(ascd_pkg::CFG_OFS, 32'h0);
      wr(ascd_pkg::CFG_OFS, 32'h0800 | (idle << 3));
      chk_cfg();
      chk("idle_level", idle, bit_clock);
      rd(ascd_pkg::STA_OFS);
      wr(ascd_pkg::DIV_OFS, (mc << 9) | (odd << 8) | n);
      wr(ascd_pkg::CFG_OFS, 32'h0C00 | (role << 8) | (idle << 3));
      wr(ascd_pkg::DIV_OFS, 32'h0005);
      rd(ascd_pkg::DIV_OFS);
      repeat (6 * n + 12) @(posedge aclk);
      @(negedge aclk);
      if (role >= 2) chk("bclk_period", 2 * n + odd, per_bc);
      else chk("bclk_slave", idle, bit_clock);
      if (on) chk("mclk_period", 2 * n + odd, per_mc);
      else chk("mclk_off", 0, master_clock);
      chk("mclk_oe_n", !on, master_clock_oe_n);
    end
    wr(ascd_pkg::CFG_OFS, 32'h0);
    chk_cfg();
    stop_test();
  end
  // Watchdog well beyond the longest sequence
  initial begin
    repeat (60000) @(posedge aclk);
    n_errors++;
    stop_test();
  end
endmodule // test_audio_serial_config_clock_div
